// *** rtl/ufc_pkg.sv ***
// Constants, types and helpers for the serial frame-format block
// Notes on behaviour
// - mode 0: data ones plus parity even
// - mode 1: data ones plus parity odd
// - parity sense ignored while parity is off
// - async transmit: one or two stop bits
// - receiver checks only the first stop bit
// - low second stop starts next character
// - five-bit field selects 5-bit characters in async mode
// - baud source 00 system, 01 subclock
// - parity enable adds and checks parity
// - synchronous mode never adds or checks parity
// - five-bit frames drop data bits 7..5
package ufc_pkg;
	// Register bus geometry
	localparam int         ADDR_W   = 5;
	localparam logic [4:0] OFS_MODE = 5'h00;
	localparam logic [4:0] OFS_TXD  = 5'h04;
	localparam logic [4:0] OFS_STAT = 5'h08;
	localparam logic [4:0] OFS_RXD  = 5'h0c;
	localparam logic [4:0] OFS_DIV  = 5'h10;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] TXD_RST  = 8'hff;
	localparam logic [7:0] DIV_RST  = 8'h00;
	// Status bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_FULL = 1;
	localparam int ST_PERR = 2;
	localparam int ST_FERR = 3;
	// Baud sources and sampling
	localparam logic [1:0] CKS_SYS  = 2'h0;
	localparam logic [1:0] CKS_SUB  = 2'h1;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID  = 4'h7;
	localparam logic [3:0] LEN_8    = 4'h8;
	localparam logic [3:0] LEN_7    = 4'h7;
	localparam logic [3:0] LEN_5    = 4'h5;

	// Mode register layout, bit 7 down to bit 0
	typedef struct packed {
		logic       sync;             // Clock synchronous mode
		logic       chr7;             // Seven-bit characters
		logic       parity_enable;
		logic       parity_odd_select;
		logic       two_stop;
		logic       five_bit_format;
		logic       baud_source_sel_hi;
		logic       baud_source_sel_lo;
	} ufc_mode_t;

	// Effective frame format after mode decoding
	typedef struct packed {
		logic [3:0] nbits;            // Data bits per frame
		logic       par;              // Parity bit present
		logic       odd;              // Odd sense
		logic       stop2;            // Second stop bit sent
	} ufc_fmt_t;

	// Receiver report to the register side
	typedef struct packed {
		logic       done;             // One-cycle frame end
		logic       perr;
		logic       ferr;
		logic [7:0] data;
	} ufc_rx_t;

	typedef enum logic [4:0] {
		SER_IDLE  = 5'h01,
		SER_START = 5'h02,
		SER_DATA  = 5'h04,
		SER_PAR   = 5'h08,
		SER_STOP  = 5'h10
	} ufc_ser_e;

	// Mode to format; sync mode drops parity and five-bit
	function automatic ufc_fmt_t ufc_decode(ufc_mode_t m);
		ufc_fmt_t f;
		f.par   = m.parity_enable & ~m.sync;
		f.odd   = m.parity_odd_select & f.par;
		f.stop2 = m.two_stop & ~m.sync;
		if (m.sync)
			f.nbits = LEN_8;
		else if (m.five_bit_format)
			f.nbits = LEN_5;
		else if (m.chr7)
			f.nbits = LEN_7;
		else
			f.nbits = LEN_8;
		return f;
	endfunction
endpackage

// *** rtl/ufc_rx.sv ***
// Frame receiver: start hunt, data, parity and first stop check
`timescale 1ns/1ps
`default_nettype none
module ufc_rx
(
	// Clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// Line and timing
	input  wire logic          rx_pin,
	input  wire logic          tick,
	input  wire ufc_pkg::ufc_fmt_t fmt,
	// Report
	output ufc_pkg::ufc_rx_t   rep
);
	import ufc_pkg::*;

	typedef struct packed {
		logic [1:0] sy;             // Pin synchroniser, two stages
		ufc_ser_e   st;
		logic [3:0] ovs;            // Sixteenth-bit counter
		logic [3:0] cnt;            // Data bit index
		logic [7:0] sh;             // Shift, filled from top
		logic       acc;            // Running parity
		ufc_rx_t    rep;
	} ufc_rxs_t;

	ufc_rxs_t s_reg;
	ufc_rxs_t s_next;
	logic     line;

	// Only the second stage feeds logic
	assign line = s_reg.sy[1];
	assign rep  = s_reg.rep;

	// Next-state logic of the receiver
	always_comb
	begin
		s_next          = s_reg;
		s_next.sy       = {s_reg.sy[0], rx_pin};
		s_next.rep.done = 1'b0;
		case (s_reg.st)
			SER_IDLE:
			begin
				// A low line here may be a low second stop bit
				if (!line)
				begin
					s_next.st  = SER_START;
					s_next.ovs = '0;
				end
			end
			SER_START:
			begin
				if (tick)
				begin
					s_next.ovs = s_reg.ovs + 4'h1;
					if (s_reg.ovs == OVS_MID)
					begin
						// Glitch rejection at mid start bit
						s_next.st  = line ? SER_IDLE : SER_DATA;
						s_next.ovs = '0;
						s_next.cnt = '0;
						s_next.acc = 1'b0;
					end
				end
			end
			SER_DATA:
			begin
				if (tick)
				begin
					s_next.ovs = s_reg.ovs + 4'h1;
					if (s_reg.ovs == OVS_LAST)
					begin
						s_next.sh  = {line, s_reg.sh[7:1]};
						s_next.acc = s_reg.acc ^ line;
						s_next.cnt = s_reg.cnt + 4'h1;
						if (s_reg.cnt == fmt.nbits - 4'h1)
							s_next.st = fmt.par ? SER_PAR : SER_STOP;
					end
				end
			end
			SER_PAR:
			begin
				if (tick)
				begin
					s_next.ovs = s_reg.ovs + 4'h1;
					if (s_reg.ovs == OVS_LAST)
					begin
						s_next.acc = s_reg.acc ^ line;
						s_next.st  = SER_STOP;
					end
				end
			end
			SER_STOP:
			begin
				if (tick)
				begin
					s_next.ovs = s_reg.ovs + 4'h1;
					if (s_reg.ovs == OVS_LAST)
					begin
						// Only the first stop is checked
						s_next.st        = SER_IDLE;
						s_next.rep.done  = 1'b1;
						s_next.rep.ferr  = ~line;
						s_next.rep.perr  = fmt.par &
							(s_reg.acc != fmt.odd);
						s_next.rep.data  = s_reg.sh >>
							(LEN_8 - fmt.nbits);
					end
				end
			end
			default:
				s_next.st = SER_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg     <= '0;
			s_reg.sy  <= 2'h3;
			s_reg.st  <= SER_IDLE;
		end
		else
			s_reg <= s_next;
	end
endmodule
`default_nettype wire

// *** rtl/ufc_top.sv ***
// Serial channel with mode register, baud source and transmitter
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ufc_top
(
	// Clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [ufc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Serial pins
	input  wire logic                      sub_clk_pin,
	input  wire logic                      rx_pin,
	output logic                           tx_pin
);
	import ufc_pkg::*;

	// Whole register-side state
	typedef struct packed {
		ufc_mode_t  mode;           // Frame format register
		logic [7:0] div;            // Baud divider
		logic [7:0] txd;            // Transmit holding
		logic [7:0] rxd;            // Last received data
		logic [7:0] bcnt;           // Baud prescale count
		logic       tick;           // Sixteen per bit
		logic [2:0] sub_s;          // Subclock synchroniser
		ufc_ser_e   tx;
		logic [3:0] tovs;
		logic [3:0] tbit;
		logic [7:0] sh;
		logic       tpar;           // Parity of current frame
		logic       txo;
		logic       full;
		logic       perr;
		logic       ferr;
		logic [31:0] rdata;
	} ufc_st_t;

	ufc_st_t  s_reg;
	ufc_st_t  s_next;
	ufc_fmt_t fmt;
	ufc_rx_t  rx;
	logic     setup;
	logic     access;
	logic     mapped;
	logic     wr;
	logic     src;
	logic     bit_end;

	assign fmt     = ufc_decode(s_reg.mode);
	assign setup   = psel & ~penable;
	assign access  = psel & penable;
	assign mapped  = paddr == OFS_MODE || paddr == OFS_TXD ||
		paddr == OFS_STAT || paddr == OFS_RXD || paddr == OFS_DIV;
	assign wr      = access & pwrite & mapped;
	// No wait states: read data was caught in setup
	assign pready  = access;
	assign pslverr = access & ~mapped;
	assign prdata  = s_reg.rdata;
	assign tx_pin  = s_reg.txo;
	assign bit_end = s_reg.tick && s_reg.tovs == OVS_LAST;

	// Receiver sees the same decoded format
	ufc_rx u_rx
	(
		.pclk    (pclk),
		.presetn (presetn),
		.rx_pin  (rx_pin),
		.tick    (s_reg.tick),
		.fmt     (fmt),
		.rep     (rx)
	);

	// Baud source select; 10 and 11 give no ticks at all
	always_comb
	begin
		case ({s_reg.mode.baud_source_sel_hi,
			s_reg.mode.baud_source_sel_lo})
			CKS_SYS: src = 1'b1;
			CKS_SUB: src = s_reg.sub_s[1] & ~s_reg.sub_s[2];
			default: src = 1'b0;
		endcase
	end

	// Next-state logic: bus, baud, transmitter, flags
	always_comb
	begin
		s_next       = s_reg;
		s_next.tick  = 1'b0;
		s_next.sub_s = {s_reg.sub_s[1:0], sub_clk_pin};

		// Prescale exponent is fixed at zero
		if (src)
		begin
			if (s_reg.bcnt == s_reg.div)
			begin
				s_next.bcnt = '0;
				s_next.tick = 1'b1;
			end
			else
				s_next.bcnt = s_reg.bcnt + 8'h01;
		end

		// Register writes
		if (wr && paddr == OFS_MODE)
			s_next.mode = pwdata[7:0];
		if (wr && paddr == OFS_DIV)
			s_next.div = pwdata[7:0];
		if (wr && paddr == OFS_TXD)
			s_next.txd = pwdata[7:0];

		// Transmitter; a write while busy only updates holding
		if (s_reg.tick)
			s_next.tovs = s_reg.tovs + 4'h1;
		case (s_reg.tx)
			SER_IDLE:
			begin
				if (wr && paddr == OFS_TXD)
				begin
					s_next.tx   = SER_START;
					s_next.tovs = '0;
					s_next.sh   = pwdata[7:0];
					// Parity over the sent bits only
					s_next.tpar = fmt.odd ^ ^(pwdata[7:0] &
						~(8'hff << fmt.nbits));
				end
			end
			SER_START:
			begin
				if (bit_end)
				begin
					s_next.tx   = SER_DATA;
					s_next.tbit = '0;
				end
			end
			SER_DATA:
			begin
				if (bit_end)
				begin
					s_next.sh   = s_reg.sh >> 1;
					s_next.tbit = s_reg.tbit + 4'h1;
					// Upper bits never leave in short formats
					if (s_reg.tbit == fmt.nbits - 4'h1)
					begin
						s_next.tx   = fmt.par ? SER_PAR : SER_STOP;
						s_next.tbit = '0;
					end
				end
			end
			SER_PAR:
			begin
				if (bit_end)
					s_next.tx = SER_STOP;
			end
			SER_STOP:
			begin
				if (bit_end)
				begin
					if (fmt.stop2 && s_reg.tbit == 4'h0)
						s_next.tbit = 4'h1;
					else
						s_next.tx = SER_IDLE;
				end
			end
			default:
				s_next.tx = SER_IDLE;
		endcase

		// Line level follows the next state
		case (s_next.tx)
			SER_START: s_next.txo = 1'b0;
			SER_DATA:  s_next.txo = s_next.sh[0];
			SER_PAR:   s_next.txo = s_next.tpar;
			default:   s_next.txo = 1'b1;
		endcase

		// Sticky flags: write one clears, a new event wins
		if (wr && paddr == OFS_STAT)
		begin
			s_next.full = s_reg.full & ~pwdata[ST_FULL];
			s_next.perr = s_reg.perr & ~pwdata[ST_PERR];
			s_next.ferr = s_reg.ferr & ~pwdata[ST_FERR];
		end
		if (rx.done)
		begin
			s_next.full = 1'b1;
			s_next.rxd  = rx.data;
			if (rx.perr)
				s_next.perr = 1'b1;
			if (rx.ferr)
				s_next.ferr = 1'b1;
		end

		// Read data caught in the setup cycle
		if (setup)
		begin
			s_next.rdata = '0;
			case (paddr)
				OFS_MODE: s_next.rdata[7:0] = s_reg.mode;
				OFS_TXD:  s_next.rdata[7:0] = s_reg.txd;
				OFS_RXD:  s_next.rdata[7:0] = s_reg.rxd;
				OFS_DIV:  s_next.rdata[7:0] = s_reg.div;
				OFS_STAT:
				begin
					s_next.rdata[ST_BUSY] = s_reg.tx != SER_IDLE;
					s_next.rdata[ST_FULL] = s_reg.full;
					s_next.rdata[ST_PERR] = s_reg.perr;
					s_next.rdata[ST_FERR] = s_reg.ferr;
				end
				default: s_next.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg       <= '0;
			s_reg.mode  <= MODE_RST;
			s_reg.div   <= DIV_RST;
			s_reg.txd   <= TXD_RST;
			s_reg.tx    <= SER_IDLE;
			s_reg.txo   <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
endmodule
`default_nettype wire

// *** tb/ufc_chk.sv ***
// Port assertions for the serial frame-format block
`timescale 1ns/1ps
`default_nettype none
module ufc_chk
	import ufc_pkg::*;
(
	// Clock and reset
	input wire logic              pclk,
	input wire logic              presetn,
	// APB side
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// Serial side
	input wire logic              sub_clk_pin,
	input wire logic              rx_pin,
	input wire logic              tx_pin
);
	// Mode byte as last written; reads of it must match
	logic [7:0] mode_reg;
	// Address decodes to a register
	wire logic  hit = paddr inside {OFS_MODE, OFS_TXD, OFS_STAT, OFS_RXD,
		OFS_DIV};

	// Shadow of the mode register
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			mode_reg <= MODE_RST;
		else if (psel && penable && pwrite && paddr == OFS_MODE)
			mode_reg <= pwdata[7:0];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_READY: assert property (pready == (psel && penable))
		else $error("pready not tied to access phase");
	AST_SLVERR: assert property (psel && penable |-> pslverr == !hit)
		else $error("pslverr wrong for address");
	AST_UPPER: assert property (prdata[31:8] == 24'h00_0000)
		else $error("read data above bit 7 not zero");
	AST_HOLD: assert property (psel && penable |=> $stable(prdata))
		else $error("read data moved at the access edge");
	AST_MODE_READ: assert property (psel && penable && !pwrite &&
		paddr == OFS_MODE |-> prdata[7:0] == mode_reg)
		else $error("mode readback differs");
	AST_IDLE: assert property ($rose(presetn) |-> tx_pin)
		else $error("line not idle after reset");
	AST_START: assert property ($fell(tx_pin) |->
		(!tx_pin)[*8] ##1 (!tx_pin)[*8])
		else $error("start bit shorter than 16 cycles");
	AST_HIGH: assert property ($rose(tx_pin) |->
		tx_pin[*8] ##1 tx_pin[*8])
		else $error("high bit shorter than 16 cycles");
endmodule
`default_nettype wire

// *** tb/ufc_remote.sv ***
// Remote serial partner: sends frames and samples device frames
`timescale 1ns/1ps
`default_nettype none
module ufc_remote
(
	// Clock
	input wire logic pclk,
	// Serial lines
	input wire logic tx_pin,
	output logic     rx_pin
);
	// Idle line is high
	initial rx_pin = 1'b1;

	// Drive bits LSB first, stop bits come with the vector
	task automatic send(input logic [15:0] v, input int nb, input int blen);
		for (int i = 0; i < nb; i++)
		begin
			rx_pin <= v[i];
			repeat (blen) @(posedge pclk);
		end
	endtask

	// Wait for a start edge, then sample each bit at its middle
	task automatic grab(input int blen, input int nb, output logic [15:0] v);
		int k;
		v = 16'hffff;
		k = 0;
		// A frame that never starts leaves v all ones and fails compare
		while (tx_pin !== 1'b0 && k < 2000)
		begin
			@(posedge pclk);
			k++;
		end
		repeat (blen / 2) @(posedge pclk);
		for (int i = 0; i <= nb; i++)
		begin
			v[i] = tx_pin;
			repeat (blen) @(posedge pclk);
		end
	endtask
endmodule
`default_nettype wire

// *** tb/uart_frame_format_config_bench.sv ***
// Testbench for the serial frame-format block
`timescale 1ns/1ps
`default_nettype none
module uart_frame_format_config_bench;
	import ufc_pkg::*;
	// Bus and clocking
	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              pready, pslverr, last_err;
	// Serial side
	logic [1:0]        sub_div;
	logic              rx_pin, tx_pin;
	logic [15:0]       got, exp_f;
	logic [7:0]        m;
	int                err_total, checked, nb, blen;
	// Transmit formats tried in turn; five-bit ones keep parity on
	logic [7:0]        modes [9] = '{8'h00, 8'h20, 8'h30, 8'h08,
		8'h24, 8'h34, 8'h10, 8'hb8, 8'h61};

	ufc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sub_clk_pin(sub_div[1]), .rx_pin(rx_pin), .tx_pin(tx_pin));
	ufc_remote u_rem (.pclk(pclk), .tx_pin(tx_pin), .rx_pin(rx_pin));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Subclock runs at a quarter of pclk
	always @(posedge pclk) sub_div <= sub_div + 2'h1;

	task automatic end_sim();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One APB transfer; an idle edge follows so calls may chain
	task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_total++;
			end_sim();
		end
		@(posedge pclk);
	endtask

	// Expected frame bits and index of the last stop bit
	function automatic void frame(input logic [7:0] mv, input logic [7:0] d);
		int w;
		logic p;
		w = mv[7] ? 8 : mv[2] ? 5 : mv[6] ? 7 : 8;
		p = mv[4];
		exp_f = 16'hffff;
		exp_f[0] = 1'b0;
		for (int i = 0; i < w; i++)
		begin
			exp_f[i + 1] = d[i];
			p = p ^ d[i];
		end
		nb = w + 1;
		if (mv[5] && !mv[7])
		begin
			exp_f[nb] = p;
			nb++;
		end
		nb = nb + int'(mv[3] && !mv[7]);
	endfunction

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		sub_div = 2'h0;
		err_total = 0;
		checked = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_MODE, 32'h0);
		chk(rd, {24'h00_0000, MODE_RST});
		apb(1'b0, 5'h14, 32'h0);
		chk({rd[30:0], last_err}, 32'h0000_0001);
		// Each format sent by the device and sampled at mid-bit
		foreach (modes[j])
		begin
			m = modes[j];
			apb(1'b1, OFS_MODE, {24'h00_0000, m});
			// Dropped top bits have odd parity, so leaking them shows
			apb(1'b1, OFS_TXD, 32'h0000_00e7);
			blen = (m[1:0] == CKS_SUB) ? 64 : 16;
			frame(m, 8'he7);
			u_rem.grab(blen, nb, got);
			chk({16'h0, got}, {16'h0, exp_f});
			repeat (blen) @(posedge pclk);
		end
		// Received parity, good and broken, even and odd
		for (int j = 0; j < 4; j++)
		begin
			m = j[1] ? 8'h30 : 8'h20;
			apb(1'b1, OFS_MODE, {24'h00_0000, m});
			frame(m, 8'h5a ^ 8'(j));
			exp_f[9] = exp_f[9] ^ j[0];
			u_rem.send(exp_f, nb + 2, 16);
			apb(1'b0, OFS_STAT, 32'h0);
			chk(rd & 32'h0000_000c, {29'h0, j[0], 2'h0});
			apb(1'b0, OFS_RXD, 32'h0);
			chk(rd, {24'h00_0000, 8'h5a ^ 8'(j)});
			apb(1'b1, OFS_STAT, 32'h0000_000f);
		end
		// Two stops set, second stop low starts the next character
		apb(1'b1, OFS_MODE, 32'h0000_0008);
		frame(8'h08, 8'h3c);
		u_rem.send(exp_f, 10, 16);
		frame(8'h08, 8'hc3);
		u_rem.send(exp_f, 12, 16);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd & 32'h0000_000e, 32'h0000_0002);
		apb(1'b0, OFS_RXD, 32'h0);
		chk(rd, 32'h0000_00c3);
		end_sim();
	end
endmodule

bind ufc_top ufc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sub_clk_pin(sub_clk_pin), .rx_pin(rx_pin), .tx_pin(tx_pin));
`default_nettype wire
